// file: pcc_pll_clock_control.sv
// pcc_pll_clock_control: pll control, bandwidth and programming registers,
// base clock selection with changeover hold, lock change flag and irq
// assumes crystal, vco, lock and track levels arrive asynchronously and are
// slow against clk_sys; stop_mode is a level from logic on clk_sys
`timescale 1ns/1ps
module pcc_pll_clock_control (
  // system
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // analogue side
  input  wire logic        xtal_clk,
  input  wire logic        vco_clk,
  input  wire logic        lockRaw,
  input  wire logic        trackRaw,
  // system integration
  input  wire logic        osc_pll_enable,
  input  wire logic        stopMode,
  // outputs
  output logic             base_clk_out,
  output logic             xtalClkOut,
  output logic             pll_irq,
  output logic             vcoEnable,
  output logic             autoModeOut,
  output logic             acqTrackOut,
  output logic [3:0]       feedbackRatio,
  output logic [3:0]       vcoRange
);

  // ----------------------------------------------------------------
  // input filter: three stages, change taken when two and three agree
  // ----------------------------------------------------------------
  logic [pcc_pkg::N_ASYNC-1:0] syncA_ff;
  logic [pcc_pkg::N_ASYNC-1:0] syncB_ff;
  logic [pcc_pkg::N_ASYNC-1:0] syncC_ff;
  logic [pcc_pkg::N_ASYNC-1:0] filt_ff;
  logic [pcc_pkg::N_ASYNC-1:0] filtPrev_ff;
  logic [pcc_pkg::N_ASYNC-1:0] rawIn;
  logic [pcc_pkg::N_ASYNC-1:0] nxt_filt;

  assign rawIn = {trackRaw, lockRaw, vco_clk, xtal_clk};

  genvar gi;
  generate
    for (gi = 0; gi < pcc_pkg::N_ASYNC; gi = gi + 1) begin : g_filt
      assign nxt_filt[gi] = (syncB_ff[gi] == syncC_ff[gi]) ? syncC_ff[gi] : filt_ff[gi];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      syncA_ff    <= '0;
      syncB_ff    <= '0;
      syncC_ff    <= '0;
      filt_ff     <= '0;
      filtPrev_ff <= '0;
    end else begin
      syncA_ff    <= rawIn;
      syncB_ff    <= syncA_ff;
      syncC_ff    <= syncB_ff;
      filt_ff     <= nxt_filt;
      filtPrev_ff <= filt_ff;
    end
  end

  // clocks only count while the system keeps oscillator and pll enabled
  wire xtalRise = osc_pll_enable & filt_ff[pcc_pkg::IN_XTAL] & ~filtPrev_ff[pcc_pkg::IN_XTAL];
  wire vcoRise  = osc_pll_enable & filt_ff[pcc_pkg::IN_VCO] & ~filtPrev_ff[pcc_pkg::IN_VCO];
  wire lockLvl  = filt_ff[pcc_pkg::IN_LOCK];
  wire lockEdge = filt_ff[pcc_pkg::IN_LOCK] ^ filtPrev_ff[pcc_pkg::IN_LOCK];

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  logic ack_ff;
  wire  access  = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire  wrLane  = access & wb_we_i & wb_sel_i[0];
  wire  rdAcc   = access & ~wb_we_i;
  wire  hitCtrl = wb_adr_i[7:2] == pcc_pkg::ADR_CTRL[7:2];
  wire  hitBw   = wb_adr_i[7:2] == pcc_pkg::ADR_BWCTL[7:2];
  wire  hitProg = wb_adr_i[7:2] == pcc_pkg::ADR_PROG[7:2];
  wire  wrCtrl  = wrLane & hitCtrl;
  wire  wrBw    = wrLane & hitBw;
  wire  wrProg  = wrLane & hitProg;
  wire  rdCtrl  = rdAcc & hitCtrl;
  wire [7:0] wd = wb_dat_i[7:0];

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  pcc_pkg::pcc_ctrl_s ctrl_ff;
  logic       auto_ff;
  logic       acqSaved_ff;
  logic       refLoss_ff;
  logic [3:0] ratio_ff;
  logic [3:0] range_ff;

  wire rangeZero = range_ff == pcc_pkg::NIB_ZERO;
  wire wLoopOn   = wd[pcc_pkg::BIT_LOW];
  wire wSel      = wd[pcc_pkg::BIT_FOUR];

  pcc_pkg::pcc_ctrl_s nxt_ctrl;
  // select only sets from an already running loop, never with range zero
  wire selAllowed = ctrl_ff.loopOn & ~rangeZero;
  // loop stays on while the vco is still the selected source
  wire loopHold   = ctrl_ff.baseSel;
  wire chgSet     = auto_ff & lockEdge;

  assign nxt_ctrl.irqEn   = (wrCtrl & auto_ff) ? wd[pcc_pkg::BIT_HI] : ctrl_ff.irqEn;
  // a lock change in the same cycle as the clearing read wins
  assign nxt_ctrl.lockChg = chgSet | (ctrl_ff.lockChg & ~rdCtrl);
  assign nxt_ctrl.loopOn  = wrCtrl ? (wLoopOn | loopHold) : ctrl_ff.loopOn;
  assign nxt_ctrl.baseSel = (stopMode | rangeZero) ? 1'b0 :
                            wrCtrl ? (wSel & (selAllowed | ctrl_ff.baseSel)) : ctrl_ff.baseSel;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= '{irqEn: 1'b0, lockChg: 1'b0, loopOn: 1'b1, baseSel: 1'b0};
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // bandwidth control; test nibble is not stored
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      auto_ff     <= 1'b0;
      acqSaved_ff <= 1'b0;
    end else if (wrBw) begin
      auto_ff     <= wd[pcc_pkg::BIT_HI];
      // the manual value survives auto mode untouched
      acqSaved_ff <= auto_ff ? acqSaved_ff : wd[pcc_pkg::BIT_LOW];
    end
  end

  // ref loss: software arms it, a crystal edge disarms it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      refLoss_ff <= 1'b0;
    end else if (wrBw & wd[pcc_pkg::BIT_FOUR] & ctrl_ff.baseSel) begin
      refLoss_ff <= 1'b1;
    end else if (xtalRise | ~ctrl_ff.baseSel) begin
      refLoss_ff <= 1'b0;
    end
  end

  // programming register, frozen while the loop runs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ratio_ff <= pcc_pkg::RATIO_RST;
      range_ff <= pcc_pkg::RANGE_RST;
    end else if (wrProg & ~ctrl_ff.loopOn) begin
      ratio_ff <= wd[7:4];
      range_ff <= wd[3:0];
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire lockRd  = auto_ff & lockLvl;
  wire acqRd   = auto_ff ? filt_ff[pcc_pkg::IN_TRACK] : acqSaved_ff;
  wire [7:0] ctrlRd = {ctrl_ff.irqEn & auto_ff,
                       ctrl_ff.lockChg & auto_ff,
                       ctrl_ff.loopOn, ctrl_ff.baseSel,
                       pcc_pkg::NIB_ONES};
  wire [7:0] bwRd   = {auto_ff, lockRd, acqRd,
                       refLoss_ff & ctrl_ff.baseSel,
                       pcc_pkg::NIB_ZERO};
  wire [7:0] progRd = {ratio_ff, range_ff};
  wire [7:0] rdMux  = hitCtrl ? ctrlRd : hitBw ? bwRd : hitProg ? progRd : 8'h00;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_ff   <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_ff   <= access;
      wb_dat_o <= rdAcc ? {24'h00_0000, rdMux} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;

  // ----------------------------------------------------------------
  // base clock changeover and halving
  // ----------------------------------------------------------------
  pcc_pkg::pcc_sw_e swState_ff;
  pcc_pkg::pcc_sw_e nxt_swState;
  logic       curSrc_ff;
  logic [1:0] swCnt_ff;
  logic [1:0] nxt_swCnt;
  logic       nxt_curSrc;
  logic       baseClk_ff;

  // select one is the vco, zero the crystal
  wire srcRise = curSrc_ff ? vcoRise : xtalRise;
  wire lastEdg = srcRise & (swCnt_ff == pcc_pkg::SW_EDGES - 2'h1);

  always_comb begin
    nxt_swState = swState_ff;
    nxt_swCnt   = swCnt_ff;
    nxt_curSrc  = curSrc_ff;
    unique case (swState_ff)
      pcc_pkg::SW_RUN: begin
        if (ctrl_ff.baseSel != curSrc_ff) begin
          nxt_swState = pcc_pkg::SW_OLD;
          nxt_swCnt   = 2'h0;
        end
      end
      pcc_pkg::SW_OLD: begin
        // let the old source run out before taking the new one
        if (lastEdg) begin
          nxt_swState = pcc_pkg::SW_NEW;
          nxt_swCnt   = 2'h0;
          nxt_curSrc  = ctrl_ff.baseSel;
        end else if (srcRise) begin
          nxt_swCnt = swCnt_ff + 2'h1;
        end
      end
      pcc_pkg::SW_NEW: begin
        if (lastEdg) begin
          nxt_swState = pcc_pkg::SW_RUN;
          nxt_swCnt   = 2'h0;
        end else if (srcRise) begin
          nxt_swCnt = swCnt_ff + 2'h1;
        end
      end
      default: begin
        nxt_swState = pcc_pkg::SW_RUN;
        nxt_swCnt   = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      swState_ff <= pcc_pkg::SW_RUN;
      swCnt_ff   <= 2'h0;
      curSrc_ff  <= 1'b0;
      baseClk_ff <= 1'b0;
    end else if (stopMode) begin
      // stop drops straight to the crystal with the output parked low
      swState_ff <= pcc_pkg::SW_RUN;
      swCnt_ff   <= 2'h0;
      curSrc_ff  <= 1'b0;
      baseClk_ff <= 1'b0;
    end else begin
      swState_ff <= nxt_swState;
      swCnt_ff   <= nxt_swCnt;
      curSrc_ff  <= nxt_curSrc;
      // one toggle per source edge gives half rate and even duty
      if (swState_ff == pcc_pkg::SW_RUN && srcRise) begin
        baseClk_ff <= ~baseClk_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      base_clk_out  <= 1'b0;
      xtalClkOut    <= 1'b0;
      pll_irq       <= 1'b0;
      vcoEnable     <= 1'b0;
      autoModeOut   <= 1'b0;
      acqTrackOut   <= 1'b0;
      feedbackRatio <= pcc_pkg::RATIO_RST;
      vcoRange      <= pcc_pkg::RANGE_RST;
    end else begin
      base_clk_out  <= baseClk_ff & ~stopMode;
      xtalClkOut    <= filt_ff[pcc_pkg::IN_XTAL] & osc_pll_enable & ~stopMode;
      pll_irq       <= ctrl_ff.lockChg & ctrl_ff.irqEn & auto_ff & ~stopMode;
      vcoEnable     <= ctrl_ff.loopOn & ~rangeZero & osc_pll_enable & ~stopMode;
      autoModeOut   <= auto_ff;
      acqTrackOut   <= acqRd;
      feedbackRatio <= (ratio_ff == pcc_pkg::NIB_ZERO) ? pcc_pkg::RATIO_MIN : ratio_ff;
      vcoRange      <= range_ff;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_irq_source: assert property (@(posedge clk_sys) disable iff (!rstn)
    pll_irq |-> $past(ctrl_ff.lockChg) && $past(ctrl_ff.irqEn) && $past(auto_ff))
    else $error("irq without flag, enable and auto");

  chk_flag_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rdCtrl && !chgSet) |=> !ctrl_ff.lockChg)
    else $error("control read left the flag set");

  chk_flag_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
    chgSet |=> ctrl_ff.lockChg)
    else $error("lock change lost");

  chk_loop_held: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctrl_ff.baseSel |-> ctrl_ff.loopOn)
    else $error("vco selected with loop off");

  chk_sel_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrCtrl && !ctrl_ff.loopOn) |=> !ctrl_ff.baseSel)
    else $error("select set from loop off");

  chk_range_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    rangeZero |=> !ctrl_ff.baseSel ##1 !vcoEnable)
    else $error("range zero kept vco");

  chk_manual_reads: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rdAcc && hitCtrl && !auto_ff) |=> wb_ack_o && wb_dat_o[7:6] == 2'h0 && wb_dat_o[3:0] == pcc_pkg::NIB_ONES)
    else $error("manual control read wrong");

  chk_loss_gated: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rdAcc && hitBw && !ctrl_ff.baseSel) |=> !wb_dat_o[4])
    else $error("ref loss seen on crystal");

  chk_prog_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrProg && ctrl_ff.loopOn) |=> $stable(ratio_ff) && $stable(range_ff))
    else $error("programming changed while loop on");

  chk_switch_static: assert property (@(posedge clk_sys) disable iff (!rstn)
    (swState_ff != pcc_pkg::SW_RUN && !stopMode) |=> $stable(baseClk_ff))
    else $error("base clock moved during changeover");

  chk_stop_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    stopMode |=> !base_clk_out && !pll_irq && !xtalClkOut && !ctrl_ff.baseSel)
    else $error("stop left outputs running");

  // manual mode must silence the request whatever the hidden enable holds
  chk_irq_manual: assert property (@(posedge clk_sys) disable iff (!rstn)
    !auto_ff |=> !pll_irq)
    else $error("irq raised in manual mode");

  chk_irqen_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrCtrl && !auto_ff) |=> $stable(ctrl_ff.irqEn))
    else $error("irq enable written in manual mode");

  chk_low_ones: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rdAcc && hitCtrl) |=> wb_dat_o[3:0] == pcc_pkg::NIB_ONES)
    else $error("control low nibble not ones");

  chk_lock_manual: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rdAcc && hitBw && !auto_ff) |=> !wb_dat_o[6])
    else $error("lock seen in manual mode");

  // an auto-mode write must not disturb the saved manual acq value
  chk_acq_saved: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrBw && auto_ff) |=> $stable(acqSaved_ff))
    else $error("saved acq value changed in auto mode");

  chk_base_toggle: assert property (@(posedge clk_sys) disable iff (!rstn)
    (swState_ff == pcc_pkg::SW_RUN && srcRise && !stopMode) |=> $changed(baseClk_ff))
    else $error("base clock missed a source edge");

  chk_ratio_min: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ratio_ff == pcc_pkg::NIB_ZERO) |=> feedbackRatio == pcc_pkg::RATIO_MIN)
    else $error("ratio zero not taken as one");

endmodule : pcc_pll_clock_control

// file: pcc_pkg.sv
// pcc_pkg: constants, field layouts and types of the pll clock control block
// assumes a classic wishbone master with 32-bit data; registers use byte lane 0
package pcc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_BWCTL = 8'h04;
  localparam logic [7:0] ADR_PROG  = 8'h08;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_HI     = 7;
  localparam int         BIT_MID    = 6;
  localparam int         BIT_LOW    = 5;
  localparam int         BIT_FOUR   = 4;
  localparam logic [3:0] NIB_ONES   = 4'hF;
  localparam logic [3:0] NIB_ZERO   = 4'h0;
  localparam logic [3:0] RATIO_MIN  = 4'h1;
  localparam logic [3:0] RATIO_RST  = 4'h6;
  localparam logic [3:0] RANGE_RST  = 4'h6;
  localparam logic [1:0] SW_EDGES   = 2'h3;

  // asynchronous inputs sampled by the three-stage filter
  localparam int IN_XTAL  = 0;
  localparam int IN_VCO   = 1;
  localparam int IN_LOCK  = 2;
  localparam int IN_TRACK = 3;
  localparam int N_ASYNC  = 4;

  typedef struct packed {
    logic irqEn;
    logic lockChg;
    logic loopOn;
    logic baseSel;
  } pcc_ctrl_s;

  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_OLD = 2'b01,
    SW_NEW = 2'b10
  } pcc_sw_e;

endpackage : pcc_pkg

// file: pcc_osc_model.sv
// pcc_osc_model: crystal, vco and lock detector stand-in for the clock control block
// assumes clk_sys is fast against both clocks; half periods are counted in clk_sys cycles
`timescale 1ns/1ps
module pcc_osc_model #(
  parameter int XHALF = 8,
  parameter int VHALF = 5
) (
  // system
  input  wire logic clk_sys,
  input  wire logic rstn,
  // controls from the bench, vco enable from the block
  input  wire logic oscOn,
  input  wire logic lockIn,
  input  wire logic trackIn,
  input  wire logic vcoEnable,
  // a held crystal stands in for a lost reference
  input  wire logic xtalHold,
  // towards the block
  output logic      xtal_clk,
  output logic      vco_clk,
  output logic      lockRaw,
  output logic      trackRaw,
  output logic      osc_pll_enable
);
  int   xCnt_ff;
  int   vCnt_ff;
  logic xtal_ff;
  logic vco_ff;

  assign osc_pll_enable = oscOn;
  assign xtal_clk       = xtal_ff;
  assign vco_clk        = vco_ff;

  // clocks stand still low while disabled, as a dead oscillator would
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      xCnt_ff <= 0;
      vCnt_ff <= 0;
      xtal_ff <= 1'b0;
      vco_ff  <= 1'b0;
    end else begin
      xCnt_ff <= (!oscOn || xtalHold || xCnt_ff == XHALF - 1) ? 0 : xCnt_ff + 1;
      vCnt_ff <= (!(oscOn && vcoEnable) || vCnt_ff == VHALF - 1) ? 0 : vCnt_ff + 1;
      xtal_ff <= !oscOn ? 1'b0 : xtalHold ? xtal_ff : (xCnt_ff == XHALF - 1) ? !xtal_ff : xtal_ff;
      vco_ff  <= !(oscOn && vcoEnable) ? 1'b0 : (vCnt_ff == VHALF - 1) ? !vco_ff : vco_ff;
    end
  end

  // lock and track follow the bench's wishes one cycle late
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lockRaw  <= 1'b0;
      trackRaw <= 1'b0;
    end else begin
      lockRaw  <= lockIn;
      trackRaw <= trackIn;
    end
  end
endmodule : pcc_osc_model

// file: testbench.sv
// testbench: self-checking bench of the pll clock control block
// assumes the osc model gives a 16-cycle crystal and a 10-cycle vco period
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] datI = 32'h0000_0000;
  logic [31:0] datO;
  logic        ack;
  logic [7:0]  rd;
  logic        oscOn = 1'b1;
  logic        lockIn = 1'b0;
  logic        trackIn = 1'b0;
  logic        stopMode = 1'b0;
  logic        xtalHold = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [3:0]  selLane = 4'h1;
  logic        xtal, vco, lockRaw, trackRaw, oscEn;
  logic        base_clk_out, xtalClkOut, pll_irq, vcoEnable, autoModeOut, acqTrackOut;
  logic [3:0]  feedbackRatio, vcoRange;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #5 clk_sys = !clk_sys;

  pcc_osc_model pcc_osc_model_inst (.clk_sys(clk_sys), .rstn(rstn), .oscOn(oscOn), .lockIn(lockIn),
    .trackIn(trackIn), .vcoEnable(vcoEnable), .xtalHold(xtalHold), .xtal_clk(xtal), .vco_clk(vco),
    .lockRaw(lockRaw),
    .trackRaw(trackRaw), .osc_pll_enable(oscEn));

  pcc_pll_clock_control pcc_pll_clock_control_inst (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .xtal_clk(xtal), .vco_clk(vco), .lockRaw(lockRaw), .trackRaw(trackRaw),
    .osc_pll_enable(oscEn), .stopMode(stopMode), .base_clk_out(base_clk_out), .xtalClkOut(xtalClkOut),
    .pll_irq(pll_irq), .vcoEnable(vcoEnable), .autoModeOut(autoModeOut), .acqTrackOut(acqTrackOut),
    .feedbackRatio(feedbackRatio), .vcoRange(vcoRange));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // hang guard: the whole run needs under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= selLane;
    datI <= {24'h00_0000, d};
    @(posedge clk_sys);
    while (ack !== 1'b1) @(posedge clk_sys);
    rd = datO[7:0];
    cyc <= 1'b0;
  endtask : wb_xfer

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    wb_xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h00_0000, e}, {24'h00_0000, rd});
  endtask : rdchk

  // waits out a changeover, then times one base clock period
  task automatic base_period(input int per);
    int h;
    int l;
    h = 0;
    l = 0;
    repeat (96) @(posedge clk_sys);
    // sampled on the falling edge, where the registered output has settled
    while (base_clk_out !== 1'b0) @(negedge clk_sys);
    while (base_clk_out !== 1'b1) @(negedge clk_sys);
    while (base_clk_out === 1'b1) begin
      @(negedge clk_sys);
      h++;
    end
    while (base_clk_out === 1'b0) begin
      @(negedge clk_sys);
      l++;
    end
    chk("base high", 32'(per), 32'(h));
    chk("base low", 32'(per), 32'(l));
  endtask : base_period

  task automatic t_regs;
    rdchk(8'h00, 8'h2F);
    rdchk(8'h04, 8'h00);
    rdchk(8'h08, 8'h66);
    rdchk(8'h0C, 8'h00);
    wb_xfer(1'b1, 8'h00, 8'hA0);
    rdchk(8'h00, 8'h2F);
    wb_xfer(1'b1, 8'h08, 8'h35);
    rdchk(8'h08, 8'h66);
    selLane = 4'h2;
    wb_xfer(1'b1, 8'h00, 8'h00);
    selLane = 4'h1;
    rdchk(8'h00, 8'h2F); // lane 0 off, write dropped, loop stays on
    base_period(16);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_select;
    wb_xfer(1'b1, 8'h00, 8'h00);
    rdchk(8'h00, 8'h0F);
    wb_xfer(1'b1, 8'h08, 8'h05);
    @(negedge clk_sys);
    chk("ratio", 32'h0000_0001, {28'h000_0000, feedbackRatio});
    chk("range", 32'h0000_0005, {28'h000_0000, vcoRange});
    wb_xfer(1'b1, 8'h00, 8'h30);
    rdchk(8'h00, 8'h2F);
    wb_xfer(1'b1, 8'h00, 8'h30);
    rdchk(8'h00, 8'h3F);
    wb_xfer(1'b1, 8'h00, 8'h10);
    rdchk(8'h00, 8'h3F);
    chk("vco on", 32'h0000_0001, {31'h0000_0000, vcoEnable});
    base_period(10);
    @(posedge clk_sys);
    xtalHold <= 1'b1;
    repeat (8) @(posedge clk_sys);
    wb_xfer(1'b1, 8'h04, 8'h10); // arm, low test bits written as zero
    repeat (64) @(posedge clk_sys);
    rdchk(8'h04, 8'h10); // reference lost
    xtalHold <= 1'b0;
    repeat (64) @(posedge clk_sys);
    rdchk(8'h04, 8'h00); // reference back
    wb_xfer(1'b1, 8'h00, 8'h20);
    rdchk(8'h04, 8'h00);
    base_period(16);
    $display("t_select done");
  endtask : t_select

  task automatic t_range0;
    wb_xfer(1'b1, 8'h00, 8'h00);
    wb_xfer(1'b1, 8'h08, 8'h50);
    wb_xfer(1'b1, 8'h00, 8'h20);
    wb_xfer(1'b1, 8'h00, 8'h30);
    rdchk(8'h00, 8'h2F);
    chk("vco enable", 32'h0000_0000, {31'h0000_0000, vcoEnable});
    wb_xfer(1'b1, 8'h00, 8'h00);
    wb_xfer(1'b1, 8'h08, 8'h66);
    wb_xfer(1'b1, 8'h00, 8'h20);
    $display("t_range0 done");
  endtask : t_range0

  task automatic t_auto;
    wb_xfer(1'b1, 8'h04, 8'h20);
    rdchk(8'h04, 8'h20);
    lockIn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rdchk(8'h00, 8'h2F);
    rdchk(8'h04, 8'h20);
    wb_xfer(1'b1, 8'h04, 8'hA0);
    rdchk(8'h04, 8'hC0);
    trackIn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rdchk(8'h04, 8'hE0);
    chk("auto outs", 32'h0000_0003, {30'h0000_0000, autoModeOut, acqTrackOut});
    wb_xfer(1'b1, 8'h00, 8'hA0);
    rdchk(8'h00, 8'hAF);
    lockIn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("irq set", 32'h0000_0001, {31'h0000_0000, pll_irq});
    rdchk(8'h00, 8'hEF);
    rdchk(8'h00, 8'hAF);
    repeat (2) @(posedge clk_sys);
    chk("irq clear", 32'h0000_0000, {31'h0000_0000, pll_irq});
    wb_xfer(1'b1, 8'h04, 8'h00);
    rdchk(8'h04, 8'h20);
    rdchk(8'h00, 8'h2F);
    trackIn <= 1'b0;
    $display("t_auto done");
  endtask : t_auto

  task automatic t_stop;
    wb_xfer(1'b1, 8'h00, 8'h30);
    rdchk(8'h00, 8'h3F);
    stopMode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("stop outs", 32'h0000_0000, {29'h0000_0000, base_clk_out, xtalClkOut, pll_irq});
    rdchk(8'h00, 8'h2F);
    stopMode <= 1'b0;
    base_period(16);
    $display("t_stop done");
  endtask : t_stop

  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_select();
    t_range0();
    t_auto();
    t_stop();
    finish_test();
  end
endmodule : testbench
